// file: msx_pkg.sv
// Purpose: Shared constants, types and decode helpers for the media crossbar
// Assumes: Single clock domain, one outstanding transfer per master connection
// Notes:   Slave port and master connection numbering is fixed here
package msx_pkg;

    localparam int DATA_W     = 64;
    localparam int BE_W       = DATA_W / 8;
    localparam int ADDR_W     = 32;
    localparam int NUM_MST    = 11;
    localparam int NUM_SLV    = 7;
    localparam int NUM_TGT    = 5;
    localparam int NUM_PERIPH = 3;
    localparam int NUM_DMA    = 4;
    localparam int MST_IDX_W  = 4;
    localparam int SLV_IDX_W  = 3;

    // Master connection numbering
    localparam int MST_CPU    = 0;
    localparam int MST_VIDEO  = 1;
    localparam int MST_PERIPH = 2;
    localparam int MST_DMA_RD = 3;
    localparam int MST_DMA_WR = 7;

    // Slave port numbering
    localparam logic [SLV_IDX_W-1:0] SLV_CPU_MEM0 = 3'h0;
    localparam logic [SLV_IDX_W-1:0] SLV_CPU_MEM1 = 3'h1;
    localparam logic [SLV_IDX_W-1:0] SLV_MPEG_JPEG = 3'h2;
    localparam logic [SLV_IDX_W-1:0] SLV_HD_MEM   = 3'h3;
    localparam logic [SLV_IDX_W-1:0] SLV_CFG      = 3'h4;
    localparam logic [SLV_IDX_W-1:0] SLV_DDR0     = 3'h5;
    localparam logic [SLV_IDX_W-1:0] SLV_DDR1     = 3'h6;

    // Address map: region in the top nibble, bank bit interleaves dual ports
    localparam int              REGION_HI  = 31;
    localparam int              REGION_LO  = 28;
    localparam int              BANK_BIT   = 12;
    localparam logic [3:0]      REG_CPU    = 4'h0;
    localparam logic [3:0]      REG_MJ     = 4'h1;
    localparam logic [3:0]      REG_HD     = 4'h2;
    localparam logic [3:0]      REG_CFG    = 4'h3;

    typedef enum logic [2:0] {
        TGT_CPU_MEM   = 3'b000,
        TGT_MPEG_JPEG = 3'b001,
        TGT_HD_MEM    = 3'b010,
        TGT_CFG       = 3'b011,
        TGT_DDR       = 3'b100,
        TGT_NONE      = 3'b111
    } msx_tgt_t;

    // Reachable targets per master, bit order {ddr, cfg, hd, mj, cpu}
    localparam logic [NUM_TGT-1:0] ALLOW_ALL    = 5'h1f;
    localparam logic [NUM_TGT-1:0] ALLOW_VIDEO  = 5'h14;
    localparam logic [NUM_TGT-1:0] ALLOW_PERIPH = 5'h11;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_REQ  = 2'b01,
        ST_WAIT = 2'b10
    } msx_slv_st_t;

    typedef struct packed {
        logic              valid;
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [BE_W-1:0]   be;
    } msx_req_t;

    typedef struct packed {
        logic              valid;
        logic              err;
        logic [DATA_W-1:0] rdata;
    } msx_rsp_t;

    function automatic msx_tgt_t tgt_decode(input logic [ADDR_W-1:0] addr);
        if (addr[REGION_HI]) return TGT_DDR;
        unique case (addr[REGION_HI:REGION_LO])
            REG_CPU: return TGT_CPU_MEM;
            REG_MJ:  return TGT_MPEG_JPEG;
            REG_HD:  return TGT_HD_MEM;
            REG_CFG: return TGT_CFG;
            default: return TGT_NONE;
        endcase
    endfunction : tgt_decode

    function automatic logic [NUM_TGT-1:0] allow_mask(input int mst);
        if (mst == MST_VIDEO) return ALLOW_VIDEO;
        if (mst == MST_PERIPH) return ALLOW_PERIPH;
        return ALLOW_ALL;
    endfunction : allow_mask

    function automatic logic [SLV_IDX_W-1:0] slv_port(input msx_tgt_t tgt,
                                                       input logic [ADDR_W-1:0] addr);
        unique case (tgt)
            TGT_CPU_MEM:   return addr[BANK_BIT] ? SLV_CPU_MEM1 : SLV_CPU_MEM0;
            TGT_MPEG_JPEG: return SLV_MPEG_JPEG;
            TGT_HD_MEM:    return SLV_HD_MEM;
            TGT_CFG:       return SLV_CFG;
            default:       return addr[BANK_BIT] ? SLV_DDR1 : SLV_DDR0;
        endcase
    endfunction : slv_port

endpackage : msx_pkg

// file: msx_rr_arbiter.sv
// Purpose: Round-robin arbiter, one grant at a time
// Assumes: Requests are same-clock levels
// Notes:   Pointer moves only when the grant is actually taken
`timescale 1ns/1ps
module msx_rr_arbiter #(
    parameter int N     = 11,
    parameter int IDX_W = 4
) (
    // Clock and reset
    input  wire logic             clk_sys_in,
    input  wire logic             sys_rst_in,
    // Requests and grant
    input  wire logic [N-1:0]     req_in,
    input  wire logic             take_in,
    output logic      [N-1:0]     grant_out,
    output logic      [IDX_W-1:0] idx_out
);
    logic [IDX_W-1:0] ptr_ff;
    logic [IDX_W-1:0] nxt_ptr;
    logic             found;
    int               j_idx;

    // Search starts just past the last winner so every requester gets a turn
    always_comb begin
        grant_out = '0;
        idx_out   = '0;
        found     = 1'b0;
        j_idx     = 0;
        for (int k = 0; k < N; k++) begin
            j_idx = (int'(ptr_ff) + 1 + k) % N;
            if (req_in[j_idx] && !found) begin
                grant_out[j_idx] = 1'b1;
                idx_out          = IDX_W'(j_idx);
                found            = 1'b1;
            end
        end
        nxt_ptr = (take_in && found) ? idx_out : ptr_ff;
    end

    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ptr_ff <= IDX_W'(N - 1);
        end else begin
            ptr_ff <= nxt_ptr;
        end
    end

endmodule : msx_rr_arbiter

// file: msx_crossbar.sv
// Purpose: System crossbar routing master transfers to memory and register slaves
// Assumes: Each master connection holds one transfer outstanding at a time
// Notes:   Illegal pairings are answered with an error and never reach a slave
`timescale 1ns/1ps
module msx_crossbar (
    // Clock and reset
    input  wire logic              clk_sys_in,
    input  wire logic              sys_rst_in,
    // Processor core master
    input  msx_pkg::msx_req_t      cpu_req_in,
    output logic                   cpu_ready_out,
    output msx_pkg::msx_rsp_t      cpu_rsp_out,
    // Video subsystem master
    input  msx_pkg::msx_req_t      video_req_in,
    output logic                   video_ready_out,
    output msx_pkg::msx_rsp_t      video_rsp_out,
    // Peripheral masters: 0 usb, 1 ethernet, 2 host port
    input  msx_pkg::msx_req_t      periph_req_in   [msx_pkg::NUM_PERIPH],
    output logic                   periph_ready_out[msx_pkg::NUM_PERIPH],
    output msx_pkg::msx_rsp_t      periph_rsp_out  [msx_pkg::NUM_PERIPH],
    // DMA transfer controller read connections
    input  msx_pkg::msx_req_t      dma_rd_req_in   [msx_pkg::NUM_DMA],
    output logic                   dma_rd_ready_out[msx_pkg::NUM_DMA],
    output msx_pkg::msx_rsp_t      dma_rd_rsp_out  [msx_pkg::NUM_DMA],
    // DMA transfer controller write connections
    input  msx_pkg::msx_req_t      dma_wr_req_in   [msx_pkg::NUM_DMA],
    output logic                   dma_wr_ready_out[msx_pkg::NUM_DMA],
    output msx_pkg::msx_rsp_t      dma_wr_rsp_out  [msx_pkg::NUM_DMA],
    // Slave ports
    output msx_pkg::msx_req_t      slv_req_out     [msx_pkg::NUM_SLV],
    input  wire logic              slv_ready_in    [msx_pkg::NUM_SLV],
    input  msx_pkg::msx_rsp_t      slv_rsp_in      [msx_pkg::NUM_SLV]
);
    import msx_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Master side assembly and legality
    msx_req_t               mreq     [NUM_MST];
    logic                   legal    [NUM_MST];
    logic [SLV_IDX_W-1:0]   mport    [NUM_MST];
    logic                   mready   [NUM_MST];
    logic                   err_take [NUM_MST];
    logic [NUM_MST-1:0]     arb_req  [NUM_SLV];
    logic [NUM_MST-1:0]     arb_gnt  [NUM_SLV];
    logic [MST_IDX_W-1:0]   arb_idx  [NUM_SLV];
    logic                   arb_take [NUM_SLV];

    // Shared peripheral connection
    logic [NUM_PERIPH-1:0]  p_req;
    logic [NUM_PERIPH-1:0]  p_gnt;
    logic [1:0]             p_idx;
    logic                   p_take;
    logic                   pb_busy_ff;
    logic                   nxt_pb_busy;
    logic [1:0]             pb_own_ff;
    logic [1:0]             nxt_pb_own;

    // Slave port state
    msx_slv_st_t            st_ff    [NUM_SLV];
    msx_slv_st_t            nxt_st   [NUM_SLV];
    logic [MST_IDX_W-1:0]   own_ff   [NUM_SLV];
    logic [MST_IDX_W-1:0]   nxt_own  [NUM_SLV];
    msx_req_t               sreq_ff  [NUM_SLV];
    msx_req_t               nxt_sreq [NUM_SLV];
    msx_rsp_t               rsp_ff   [NUM_MST];
    msx_rsp_t               nxt_rsp  [NUM_MST];

    // Three peripherals share one crossbar connection; it stays locked to
    // its owner until the answer returns, so answers cannot be misrouted
    always_comb begin
        for (int i = 0; i < NUM_PERIPH; i++) begin
            p_req[i]            = periph_req_in[i].valid && !pb_busy_ff;
            periph_ready_out[i] = p_gnt[i] && mready[MST_PERIPH];
            periph_rsp_out[i]   = rsp_ff[MST_PERIPH];
            periph_rsp_out[i].valid = rsp_ff[MST_PERIPH].valid && pb_busy_ff
                                      && (pb_own_ff == 2'(i));
        end
        p_take = mready[MST_PERIPH] && (|p_req);
        nxt_pb_busy = pb_busy_ff;
        nxt_pb_own  = pb_own_ff;
        if (!pb_busy_ff && p_take) begin
            nxt_pb_busy = 1'b1;
            nxt_pb_own  = p_idx;
        end else if (pb_busy_ff && rsp_ff[MST_PERIPH].valid) begin
            nxt_pb_busy = 1'b0;
        end
    end

    msx_rr_arbiter #(
        .N     (NUM_PERIPH),
        .IDX_W (2)
    ) u_periph_arb (
        .clk_sys_in (clk_sys_in),
        .sys_rst_in (sys_rst_in),
        .req_in     (p_req),
        .take_in    (p_take),
        .grant_out  (p_gnt),
        .idx_out    (p_idx)
    );

    // Eleven master connections built into one array
    always_comb begin
        mreq[MST_CPU]    = cpu_req_in;
        mreq[MST_VIDEO]  = video_req_in;
        mreq[MST_PERIPH] = periph_req_in[p_idx];
        mreq[MST_PERIPH].valid = |p_req;
        for (int d = 0; d < NUM_DMA; d++) begin
            mreq[MST_DMA_RD + d] = dma_rd_req_in[d];
            mreq[MST_DMA_WR + d] = dma_wr_req_in[d];
        end
        for (int m = 0; m < NUM_MST; m++) begin
            msx_tgt_t           tgt;
            logic [NUM_TGT-1:0] amask;
            tgt      = tgt_decode(mreq[m].addr);
            amask    = allow_mask(m);
            mport[m] = slv_port(tgt, mreq[m].addr);
            legal[m] = (tgt != TGT_NONE) && amask[tgt[2:0]];
            if (m >= MST_DMA_RD && m < MST_DMA_WR) begin
                legal[m] = legal[m] && !mreq[m].wr;
            end else if (m >= MST_DMA_WR) begin
                legal[m] = legal[m] && mreq[m].wr;
            end
        end
        for (int s = 0; s < NUM_SLV; s++) begin
            for (int m = 0; m < NUM_MST; m++) begin
                // Only permitted pairings ever reach a slave arbiter
                arb_req[s][m] = mreq[m].valid && legal[m] && (mport[m] == 3'(s));
            end
            arb_take[s] = (st_ff[s] == ST_IDLE);
        end
        for (int m = 0; m < NUM_MST; m++) begin
            err_take[m] = mreq[m].valid && !legal[m];
            mready[m]   = err_take[m];
            for (int s = 0; s < NUM_SLV; s++) begin
                if (arb_take[s] && arb_gnt[s][m]) begin
                    mready[m] = 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Slave ports: one arbiter each, held until the slave answers
    for (genvar gs = 0; gs < NUM_SLV; gs++) begin : g_slv
        msx_rr_arbiter #(
            .N     (NUM_MST),
            .IDX_W (MST_IDX_W)
        ) u_arb (
            .clk_sys_in (clk_sys_in),
            .sys_rst_in (sys_rst_in),
            .req_in     (arb_req[gs]),
            .take_in    (arb_take[gs]),
            .grant_out  (arb_gnt[gs]),
            .idx_out    (arb_idx[gs])
        );
    end

    always_comb begin
        for (int m = 0; m < NUM_MST; m++) begin
            nxt_rsp[m] = '0;
            if (err_take[m]) begin
                nxt_rsp[m].valid = 1'b1;
                nxt_rsp[m].err   = 1'b1;
            end
        end
        for (int s = 0; s < NUM_SLV; s++) begin
            nxt_st[s]   = st_ff[s];
            nxt_own[s]  = own_ff[s];
            nxt_sreq[s] = sreq_ff[s];
            unique case (st_ff[s])
                ST_IDLE: begin
                    if (|arb_req[s]) begin
                        nxt_sreq[s] = mreq[arb_idx[s]];
                        nxt_own[s]  = arb_idx[s];
                        nxt_st[s]   = ST_REQ;
                    end
                end
                ST_REQ: begin
                    if (slv_ready_in[s]) begin
                        nxt_sreq[s].valid = 1'b0;
                        nxt_st[s]         = ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (slv_rsp_in[s].valid) begin
                        nxt_rsp[own_ff[s]] = slv_rsp_in[s];
                        nxt_st[s]          = ST_IDLE;
                    end
                end
                default: begin
                    nxt_st[s] = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pb_busy_ff <= 1'b0;
            pb_own_ff  <= '0;
            for (int s = 0; s < NUM_SLV; s++) begin
                st_ff[s]   <= ST_IDLE;
                own_ff[s]  <= '0;
                sreq_ff[s] <= '0;
            end
            for (int m = 0; m < NUM_MST; m++) begin
                rsp_ff[m] <= '0;
            end
        end else begin
            pb_busy_ff <= nxt_pb_busy;
            pb_own_ff  <= nxt_pb_own;
            st_ff      <= nxt_st;
            own_ff     <= nxt_own;
            sreq_ff    <= nxt_sreq;
            rsp_ff     <= nxt_rsp;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    always_comb begin
        slv_req_out     = sreq_ff;
        cpu_ready_out   = mready[MST_CPU];
        cpu_rsp_out     = rsp_ff[MST_CPU];
        video_ready_out = mready[MST_VIDEO];
        video_rsp_out   = rsp_ff[MST_VIDEO];
        for (int d = 0; d < NUM_DMA; d++) begin
            dma_rd_ready_out[d] = mready[MST_DMA_RD + d];
            dma_rd_rsp_out[d]   = rsp_ff[MST_DMA_RD + d];
            dma_wr_ready_out[d] = mready[MST_DMA_WR + d];
            dma_wr_rsp_out[d]   = rsp_ff[MST_DMA_WR + d];
        end
    end

endmodule : msx_crossbar

// file: msx_crossbar_sva.sv
// Purpose: Port checks on the media crossbar
// Assumes: One clock, reset active high
// Notes:   Watches core, video, usb, DMA read connections and the ddr0 slave port
`timescale 1ns/1ps
module msx_crossbar_sva (
    // Clock and reset
    input wire logic         clk_sys_in,
    input wire logic         sys_rst_in,
    // Masters
    input msx_pkg::msx_req_t cpu_req_in,
    input logic              cpu_ready_out,
    input msx_pkg::msx_rsp_t cpu_rsp_out,
    input msx_pkg::msx_req_t video_req_in,
    input logic              video_ready_out,
    input msx_pkg::msx_rsp_t video_rsp_out,
    input msx_pkg::msx_req_t periph_req_in   [msx_pkg::NUM_PERIPH],
    input logic              periph_ready_out[msx_pkg::NUM_PERIPH],
    input msx_pkg::msx_rsp_t periph_rsp_out  [msx_pkg::NUM_PERIPH],
    input msx_pkg::msx_req_t dma_rd_req_in   [msx_pkg::NUM_DMA],
    input logic              dma_rd_ready_out[msx_pkg::NUM_DMA],
    input msx_pkg::msx_rsp_t dma_rd_rsp_out  [msx_pkg::NUM_DMA],
    // Slave ports
    input msx_pkg::msx_req_t slv_req_out     [msx_pkg::NUM_SLV],
    input wire logic         slv_ready_in    [msx_pkg::NUM_SLV]
);
    import msx_pkg::*;
    logic [4:0] ddr0_take;
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);
    ////////////////////////////////////////////////////////////////////
    // Accepts aimed at ddr0 in one cycle; more than one means a lost grant
    always_comb begin
        ddr0_take[0] = cpu_req_in.valid && cpu_ready_out && cpu_req_in.addr[31]
                       && !cpu_req_in.addr[12];
        for (int i = 0; i < NUM_DMA; i++)
            ddr0_take[i+1] = dma_rd_req_in[i].valid && dma_rd_ready_out[i]
                             && !dma_rd_req_in[i].wr
                             && dma_rd_req_in[i].addr[31] && !dma_rd_req_in[i].addr[12];
    end
    ill_vid_a: assert property (video_req_in.valid && video_ready_out
        && !video_req_in.addr[31] && video_req_in.addr[31:28] != 4'h2
        |=> video_rsp_out.valid && video_rsp_out.err) else $error("video pairing not refused");
    ill_per_a: assert property (periph_req_in[0].valid && periph_ready_out[0]
        && !periph_req_in[0].addr[31] && periph_req_in[0].addr[31:28] != 4'h0
        |=> periph_rsp_out[0].valid && periph_rsp_out[0].err) else $error("usb pairing not refused");
    dma_dir_a: assert property (dma_rd_req_in[0].valid && dma_rd_ready_out[0]
        && dma_rd_req_in[0].wr |=> dma_rd_rsp_out[0].valid && dma_rd_rsp_out[0].err)
        else $error("write on read connection not refused");
    route_ddr_a: assert property (ddr0_take[0] |=> slv_req_out[5].valid
        && slv_req_out[5].wdata == $past(cpu_req_in.wdata)) else $error("core to ddr0 not routed");
    slv_hold_a: assert property (slv_req_out[5].valid && !slv_ready_in[5]
        |=> slv_req_out[5].valid && $stable(slv_req_out[5].addr)) else $error("slave request dropped");
    one_grant_a: assert property ($onehot0(ddr0_take)) else $error("two grants on ddr0");
    no_starve_a: assert property ($rose(cpu_req_in.valid) |-> ##[0:200] cpu_ready_out)
        else $error("core starved");
    // A refused request taken in the answer cycle may legally answer right after
    rsp_pulse_a: assert property (cpu_rsp_out.valid && !(cpu_req_in.valid && cpu_ready_out)
        |=> !cpu_rsp_out.valid) else $error("core answer longer than one cycle");
    cover property (cpu_rsp_out.valid && cpu_rsp_out.err);
    cover property (cpu_req_in.valid && dma_rd_req_in[0].valid && !cpu_ready_out);
    cover property (periph_rsp_out[2].valid);
endmodule : msx_crossbar_sva

bind msx_crossbar msx_crossbar_sva u_msx_crossbar_sva (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .cpu_req_in(cpu_req_in), .cpu_ready_out(cpu_ready_out), .cpu_rsp_out(cpu_rsp_out),
    .video_req_in(video_req_in), .video_ready_out(video_ready_out),
    .video_rsp_out(video_rsp_out), .periph_req_in(periph_req_in),
    .periph_ready_out(periph_ready_out), .periph_rsp_out(periph_rsp_out),
    .dma_rd_req_in(dma_rd_req_in), .dma_rd_ready_out(dma_rd_ready_out),
    .dma_rd_rsp_out(dma_rd_rsp_out), .slv_req_out(slv_req_out), .slv_ready_in(slv_ready_in)
);

// file: msx_slave_model.sv
// Purpose: Behavioural slave port answering after LAT wait cycles
// Assumes: One request outstanding at a time
// Notes:   Holds one word; rdata is inverted while no answer stands
`timescale 1ns/1ps
module msx_slave_model #(
    parameter int LAT = 0
) (
    // Clock and reset
    input  wire logic         clk_sys_in,
    input  wire logic         sys_rst_in,
    // Port
    input  msx_pkg::msx_req_t req_in,
    output logic              ready_out,
    output msx_pkg::msx_rsp_t rsp_out
);
    import msx_pkg::*;
    logic [7:0]        wait_ff;
    logic [DATA_W-1:0] word_ff;
    logic              ans_ff;
    assign ready_out = req_in.valid && (wait_ff == 8'(LAT));
    // Stale data is inverted so a master cannot pass by reading it late
    assign rsp_out = '{valid: ans_ff, err: 1'b0, rdata: ans_ff ? word_ff : ~word_ff};
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            wait_ff <= 8'h0;
            word_ff <= '0;
            ans_ff  <= 1'b0;
        end else begin
            ans_ff  <= ready_out;
            wait_ff <= (req_in.valid && !ready_out) ? wait_ff + 8'h1 : 8'h0;
            for (int i = 0; i < BE_W; i++)
                if (ready_out && req_in.wr && req_in.be[i])
                    word_ff[i*8 +: 8] <= req_in.wdata[i*8 +: 8];
        end
    end
endmodule : msx_slave_model

// file: test_msx_crossbar.sv
// Purpose: Self-checking bench for the media crossbar
// Assumes: Slave models wait 0 to 2 cycles before accepting
// Notes:   Master 0 core, 1 video, 2-4 periph, 5-8 DMA read, 9-12 DMA write
`timescale 1ns/1ps
module test_msx_crossbar;
    import msx_pkg::*;
    logic          clk_sys_in;
    logic          sys_rst_in;
    msx_req_t      m_req [13];
    wire logic     m_rdy [13];
    wire msx_rsp_t m_rsp [13];
    msx_rsp_t      got   [13];
    wire msx_req_t s_req [NUM_SLV];
    wire logic     s_rdy [NUM_SLV];
    wire msx_rsp_t s_rsp [NUM_SLV];
    int            failures = 0;
    int            check_count = 0;
    logic [63:0]   ddr0_v;
    logic [31:0]   tgt_a [6] = '{32'h0, 32'h1000_0000, 32'h2000_0000, 32'h3000_0000,
                                 32'h8000_0000, 32'h5000_0000};
    logic [31:0]   port_a [7] = '{32'h0, 32'h1000, 32'h1000_0000, 32'h2000_0000,
                                  32'h3000_0000, 32'h8000_0000, 32'h8000_1000};

    always #4 clk_sys_in = ~clk_sys_in;

    msx_crossbar u_msx_crossbar (
        .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
        .cpu_req_in(m_req[0]), .cpu_ready_out(m_rdy[0]), .cpu_rsp_out(m_rsp[0]),
        .video_req_in(m_req[1]), .video_ready_out(m_rdy[1]), .video_rsp_out(m_rsp[1]),
        .periph_req_in(m_req[2:4]), .periph_ready_out(m_rdy[2:4]), .periph_rsp_out(m_rsp[2:4]),
        .dma_rd_req_in(m_req[5:8]), .dma_rd_ready_out(m_rdy[5:8]), .dma_rd_rsp_out(m_rsp[5:8]),
        .dma_wr_req_in(m_req[9:12]), .dma_wr_ready_out(m_rdy[9:12]),
        .dma_wr_rsp_out(m_rsp[9:12]),
        .slv_req_out(s_req), .slv_ready_in(s_rdy), .slv_rsp_in(s_rsp)
    );

    for (genvar p = 0; p < NUM_SLV; p++) begin : g_slv
        msx_slave_model #(.LAT(p % 3)) u_msx_slave_model (
            .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
            .req_in(s_req[p]), .ready_out(s_rdy[p]), .rsp_out(s_rsp[p])
        );
    end
    ////////////////////////////////////////////////////////////////////
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_of_test;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_of_test

    // Request held until the edge that samples ready, answer taken once
    task automatic xfer(input int m, input logic wr, input logic [31:0] a,
                        input logic [63:0] d, input logic [7:0] be);
        int n;
        n = 0;
        got[m] = '0;
        m_req[m] <= '{valid: 1'b1, wr: wr, addr: a, wdata: d, be: be};
        do begin
            @(negedge clk_sys_in);
            n++;
        end while (m_rdy[m] !== 1'b1 && n < 300);
        @(posedge clk_sys_in);
        m_req[m].valid <= 1'b0;
        do begin
            @(negedge clk_sys_in);
            n++;
        end while (m_rsp[m].valid !== 1'b1 && n < 300);
        if (n >= 300) failures++;
        got[m] = m_rsp[m];
        @(posedge clk_sys_in);
    endtask : xfer

    task automatic t_matrix;
        logic [4:0] ok;
        for (int m = 0; m < 13; m++) begin
            ok = (m == 1) ? 5'h14 : (m >= 2 && m <= 4) ? 5'h11 : 5'h1f;
            for (int t = 0; t < 6; t++) begin
                xfer(m, m >= 9, tgt_a[t], 64'h0, 8'hff);
                check(64'(got[m].err), 64'(t == 5 || !ok[t]));
            end
        end
    endtask : t_matrix

    task automatic t_data;
        for (int p = 0; p < 7; p++)
            xfer(9, 1'b1, port_a[p], 64'h0123_4567_89ab_cdef ^ {8{8'(p)}}, 8'hff);
        for (int p = 0; p < 7; p++) begin
            xfer(6, 1'b0, port_a[p], 64'h0, 8'hff);
            check(got[6].rdata, 64'h0123_4567_89ab_cdef ^ {8{8'(p)}});
        end
        xfer(10, 1'b1, port_a[5], 64'hfeed_face_5555_aaaa, 8'h0f);
        ddr0_v = 64'h0426_4062_5555_aaaa;
        xfer(3, 1'b0, port_a[5], 64'h0, 8'hff);
        check(got[3].rdata, ddr0_v);
    endtask : t_data

    // Wrong direction must be refused and leave ddr0 untouched
    task automatic t_dir;
        for (int i = 0; i < 4; i++) begin
            xfer(5 + i, 1'b1, port_a[5], 64'h0, 8'hff);
            check(64'(got[5 + i].err), 64'h1);
            xfer(9 + i, 1'b0, port_a[5], 64'h0, 8'hff);
            check(64'(got[9 + i].err), 64'h1);
        end
    endtask : t_dir

    task automatic t_arb;
        int ms [8] = '{0, 5, 6, 7, 8, 2, 3, 4};
        for (int i = 0; i < 8; i++) begin
            automatic int m = ms[i];
            fork
                xfer(m, 1'b0, port_a[5], 64'h0, 8'hff);
            join_none
        end
        wait fork;
        foreach (ms[i]) check(got[ms[i]].rdata, ddr0_v);
    endtask : t_arb

    initial begin
        clk_sys_in = 1'b0;
        sys_rst_in = 1'b1;
        foreach (m_req[i]) m_req[i] = '0;
        repeat (2) @(posedge clk_sys_in);
        sys_rst_in <= 1'b0;
        @(posedge clk_sys_in);
        t_matrix();
        t_data();
        t_dir();
        t_arb();
        end_of_test();
    end

    // About 110 transfers of a few cycles each; far more means a hang
    initial begin
        #400000;
        failures++;
        end_of_test();
    end
endmodule : test_msx_crossbar
